// *** msc_stats.sv ***
// Four MIB frame statistics counters with shared threshold event.
`timescale 1ns/10ps
`include "msc_cfg.svh"
// Summary of operation
// RULE1: Count address-matched receive frames that overran the receive FIFO.
// RULE2: Frames dropped because the FIFO was full at start are not counted.
// RULE3: The 16-bit overrun counter wraps to zero after all ones.
// RULE4: Overrun counter reaching the threshold sets the threshold event.
// RULE5: Counters advance only when globally enabled and their mask bit is 0.
// RULE6: Count every frame received successfully.
// RULE7: Good-receive ignores too long, FCS, length, alignment and overrun.
// RULE8: The 32-bit good-receive counter wraps to zero after all ones.
// RULE9: Good-receive counter reaching the threshold sets the threshold event.
// RULE10: Count transmit frames whose first attempt deferred to a busy medium.
// RULE11: Frames that saw any collision are not counted as deferred.
// RULE12: The 32-bit deferred-transmit counter wraps to zero after all ones.
// RULE13: Deferred counter reaching the threshold sets the threshold event.
// RULE14: Count frames whose deferral exceeded the defer limit.
// RULE15: The excessive-deferral counter advances at most once per frame.
// RULE16: The 16-bit excessive-deferral counter wraps to zero after all ones.
// RULE17: Excess counter reaching the threshold sets the threshold event.
// RULE18: A software write loads a counter; counting resumes from that value.
// RULE19: The threshold event stays set until software clears it.
module msc_stats
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access through the I/O or memory window
    input wire logic reg_sel,
    input wire logic [`MSC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`MSC_DATA_W-1:0] reg_wdata,
    output logic [`MSC_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Statistics control from the MAC control and mask registers
    input wire logic stats_global_enable,
    input wire logic [`MSC_NCNT-1:0] stats_counter_mask,
    // Receive frame status
    input wire logic rx_start,
    input wire logic rx_fifo_full,
    input wire logic rx_overrun,
    input wire logic rx_end,
    input wire logic rx_addr_match,
    input wire logic rx_too_long,
    input wire logic rx_fcs_err,
    input wire logic rx_len_err,
    input wire logic rx_align_err,
    // Transmit frame status
    input wire logic tx_start,
    input wire logic tx_defer,
    input wire logic tx_collision,
    input wire logic tx_excess_defer,
    input wire logic tx_end,
    // Threshold event in the interrupt status register
    input wire logic stats_event_clear,
    output logic stats_threshold_event
);
    msc_state_t cur;
    msc_state_t next_cur;

    // Raw frame events before the enable and mask gate.
    logic [`MSC_NCNT-1:0] raw_inc;

    // Counter load strobes from register writes.
    logic [`MSC_NCNT-1:0] load;

    // Counter values, zero extended to the data width.
    logic [`MSC_NCNT-1:0][`MSC_DATA_W-1:0] counts;

    // Threshold pulses, one per counter.
    logic [`MSC_NCNT-1:0] reached;

    // Selected read data for the current address.
    logic [`MSC_DATA_W-1:0] mux_data;

    // Receive qualification terms at the end of a frame.
    logic rx_frame_errors;
    logic rx_overrun_any;
    logic rx_end_kept;

    // Transmit qualification terms at the end of a frame.
    logic tx_defer_any;
    logic tx_coll_any;

    // Write decode: each counter has one offset, the write is a full word.
    always_comb begin
        load = '0;
        if (reg_sel && reg_wr) begin
            load[`MSC_IX_OVERRUN] = reg_addr == `MSC_OFS_RX_OVERRUN; // RULE18
            load[`MSC_IX_EXCESS] = reg_addr == `MSC_OFS_TX_EXCESS; // RULE18
            load[`MSC_IX_GOOD] = reg_addr == `MSC_OFS_RX_GOOD; // RULE18
            load[`MSC_IX_DEFER] = reg_addr == `MSC_OFS_TX_DEFER; // RULE18
        end
    end

    // Receive terms. An overrun pulse in the end cycle still counts, so the
    // overrun and the frame end may arrive together.
    assign rx_frame_errors = rx_too_long | rx_fcs_err | rx_len_err | rx_align_err;
    assign rx_overrun_any = cur.rx_overrun_seen | rx_overrun;
    assign rx_end_kept = rx_end && (cur.rx_state == MSC_RX_FRAME);

    // Transmit terms, also folding in pulses of the end cycle itself.
    assign tx_defer_any = cur.tx_defer_seen | tx_defer;
    assign tx_coll_any = cur.tx_coll_seen | tx_collision;

    // Frame qualification into raw increment events.
    always_comb begin
        raw_inc = '0;
        // Frames dropped at start never reach the frame state.
        raw_inc[`MSC_IX_OVERRUN] = rx_end_kept && rx_addr_match
            && rx_overrun_any; // RULE1 RULE2
        raw_inc[`MSC_IX_GOOD] = rx_end_kept && rx_addr_match
            && !rx_frame_errors && !rx_overrun_any; // RULE6 RULE7
        raw_inc[`MSC_IX_DEFER] = cur.tx_active && tx_end
            && tx_defer_any && !tx_coll_any; // RULE10 RULE11
        raw_inc[`MSC_IX_EXCESS] = cur.tx_active && tx_excess_defer
            && !cur.tx_excess_done; // RULE14 RULE15
    end

    // Next state of the whole block.
    always_comb begin
        next_cur = cur;

        // Receive tracker. Whether the FIFO is full is judged once, at the
        // start; a frame dropped whole is invisible to the host.
        unique case (cur.rx_state)
            MSC_RX_IDLE: begin
                next_cur.rx_overrun_seen = 1'b0;
                if (rx_start) begin
                    next_cur.rx_state = rx_fifo_full ? MSC_RX_DROP : MSC_RX_FRAME; // RULE2
                end
            end
            MSC_RX_FRAME: begin
                if (rx_overrun) begin
                    next_cur.rx_overrun_seen = 1'b1; // RULE1
                end
                if (rx_end) begin
                    next_cur.rx_state = MSC_RX_IDLE;
                    next_cur.rx_overrun_seen = 1'b0;
                end
            end
            MSC_RX_DROP: begin
                if (rx_end) begin
                    next_cur.rx_state = MSC_RX_IDLE;
                end
            end
            default: begin
                next_cur.rx_state = MSC_RX_IDLE;
                next_cur.rx_overrun_seen = 1'b0;
            end
        endcase

        // Transmit tracker. The excess flag stays up through every deferral
        // period of the frame and drops only at the frame boundary.
        if (tx_start) begin
            next_cur.tx_active = 1'b1;
            next_cur.tx_defer_seen = tx_defer;
            next_cur.tx_coll_seen = tx_collision;
            next_cur.tx_excess_done = 1'b0;
        end else if (cur.tx_active) begin
            if (tx_defer) begin
                next_cur.tx_defer_seen = 1'b1; // RULE10
            end
            if (tx_collision) begin
                next_cur.tx_coll_seen = 1'b1; // RULE11
            end
            if (tx_excess_defer) begin
                next_cur.tx_excess_done = 1'b1; // RULE15
            end
            if (tx_end) begin
                next_cur.tx_active = 1'b0;
                next_cur.tx_defer_seen = 1'b0;
                next_cur.tx_coll_seen = 1'b0;
                next_cur.tx_excess_done = 1'b0;
            end
        end

        // Enable and mask gate; a masked event is lost, not deferred.
        next_cur.inc = raw_inc & {`MSC_NCNT{stats_global_enable}}
            & ~stats_counter_mask; // RULE5

        // Read port: data is registered and held until the next read.
        next_cur.rvalid = reg_sel && reg_rd;
        if (reg_sel && reg_rd) begin
            next_cur.rdata = mux_data;
        end

        // Sticky threshold event; a new crossing wins over a clear.
        next_cur.event_flag = (cur.event_flag && !stats_event_clear)
            || (|reached); // RULE19
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '{
                rx_state: MSC_RX_IDLE,
                rx_overrun_seen: 1'b0,
                tx_active: 1'b0,
                tx_defer_seen: 1'b0,
                tx_coll_seen: 1'b0,
                tx_excess_done: 1'b0,
                inc: '0,
                rdata: `MSC_RD_NONE,
                rvalid: 1'b0,
                event_flag: 1'b0
            };
        end else begin
            cur <= next_cur;
        end
    end

    // One counter per statistic; the first two are 16 bits, the rest 32.
    genvar gi;
    generate
        for (gi = 0; gi < `MSC_NCNT; gi++) begin : g_cnt
            if (gi < 2) begin : g_narrow
                logic [`MSC_W16-1:0] value;
                // Overrun loss and excessive deferral counters.
                msc_counter #(
                    .WIDTH(`MSC_W16),
                    .THRESH(`MSC_THRESH16),
                    .RST(`MSC_RST16)
                ) u_cnt (
                    .clk(clk),
                    .rstn(rstn),
                    .inc(cur.inc[gi]),
                    .load(load[gi]),
                    .load_value(reg_wdata[`MSC_W16-1:0]),
                    .count(value),
                    .reached(reached[gi]) // RULE4 RULE17
                );
                // Upper bits of a 16-bit counter read as zero.
                assign counts[gi] = {{(`MSC_DATA_W - `MSC_W16){1'b0}}, value};
            end else begin : g_wide
                // Good receive and deferred transmit counters.
                msc_counter #(
                    .WIDTH(`MSC_W32),
                    .THRESH(`MSC_THRESH32),
                    .RST(`MSC_RST32)
                ) u_cnt (
                    .clk(clk),
                    .rstn(rstn),
                    .inc(cur.inc[gi]),
                    .load(load[gi]),
                    .load_value(reg_wdata),
                    .count(counts[gi]),
                    .reached(reached[gi]) // RULE9 RULE13
                );
            end
        end
    endgenerate

    // Address to read data.
    msc_read_mux u_rd (
        .addr(reg_addr),
        .counts(counts),
        .data(mux_data)
    );

    // Outputs come straight from the state register.
    assign reg_rdata = cur.rdata;
    assign reg_rvalid = cur.rvalid;
    assign stats_threshold_event = cur.event_flag; // RULE4 RULE9 RULE13 RULE17
endmodule : msc_stats

// *** msc_cfg.svh ***
// Constants for the MAC frame statistics counter block.
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// Register port address width and data width.
`define MSC_ADDR_W 8
`define MSC_DATA_W 32

// Counter register offsets in the I/O and memory windows.
`define MSC_OFS_RX_GOOD 8'hb4
`define MSC_OFS_TX_DEFER 8'he4
`define MSC_OFS_RX_OVERRUN 8'hb8
`define MSC_OFS_TX_EXCESS 8'he8

// Counter widths.
`define MSC_W16 16
`define MSC_W32 32

// Threshold values that raise the statistics threshold event.
`define MSC_THRESH16 16'hc000
`define MSC_THRESH32 32'hc0000000

// Counter reset values.
`define MSC_RST16 16'h0000
`define MSC_RST32 32'h00000000

// Counter indices, also the bit positions in the statistics mask.
`define MSC_NCNT 4
`define MSC_IX_OVERRUN 0
`define MSC_IX_EXCESS 1
`define MSC_IX_GOOD 2
`define MSC_IX_DEFER 3

// Value returned for an unmapped read.
`define MSC_RD_NONE 32'h00000000

`endif

// *** msc_pkg.sv ***
// Types shared by the frame statistics counter block.
package msc_pkg;

    // Receive frame tracking, Gray coded along idle, frame, drop.
    typedef enum logic [1:0] {
        MSC_RX_IDLE = 2'b00,
        MSC_RX_FRAME = 2'b01,
        MSC_RX_DROP = 2'b11
    } msc_rx_state_t;

    // Complete state of the top module.
    typedef struct packed {
        msc_rx_state_t rx_state;
        logic rx_overrun_seen;
        logic tx_active;
        logic tx_defer_seen;
        logic tx_coll_seen;
        logic tx_excess_done;
        logic [3:0] inc;
        logic [31:0] rdata;
        logic rvalid;
        logic event_flag;
    } msc_state_t;

endpackage : msc_pkg

// *** msc_counter.sv ***
// Wrapping statistics counter with software load and threshold pulse.
`timescale 1ns/10ps
module msc_counter #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] THRESH = {WIDTH{1'b1}},
    parameter logic [WIDTH-1:0] RST = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Count control
    input wire logic inc,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // Results
    output logic [WIDTH-1:0] count,
    output logic reached
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic reached;
    } msc_cnt_state_t;

    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    msc_cnt_state_t cur;
    msc_cnt_state_t next_cur;

    // A load beats an increment in the same cycle so software sees exactly
    // what it wrote; the lost event is one count at most.
    always_comb begin
        next_cur = cur;
        next_cur.reached = 1'b0;
        if (load) begin
            next_cur.count = load_value; // RULE18
        end else if (inc) begin
            // All ones plus one falls back to zero by the register width.
            next_cur.count = cur.count + ONE; // RULE3 RULE8 RULE12 RULE16
            next_cur.reached = (cur.count + ONE) == THRESH;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '{count: RST, reached: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign count = cur.count;
    assign reached = cur.reached;
endmodule : msc_counter

// *** msc_read_mux.sv ***
// Read data selection for the statistics counter registers.
`timescale 1ns/10ps
`include "msc_cfg.svh"
module msc_read_mux (
    // Address
    input wire logic [`MSC_ADDR_W-1:0] addr,
    // Counter values, zero extended
    input wire logic [`MSC_NCNT-1:0][`MSC_DATA_W-1:0] counts,
    // Selected data
    output logic [`MSC_DATA_W-1:0] data
);
    // Unmapped offsets read as zero.
    always_comb begin
        case (addr)
            `MSC_OFS_RX_OVERRUN: data = counts[`MSC_IX_OVERRUN];
            `MSC_OFS_TX_EXCESS: data = counts[`MSC_IX_EXCESS];
            `MSC_OFS_RX_GOOD: data = counts[`MSC_IX_GOOD];
            `MSC_OFS_TX_DEFER: data = counts[`MSC_IX_DEFER];
            default: data = `MSC_RD_NONE;
        endcase
    end
endmodule : msc_read_mux

// *** msc_stats_sva.sv ***
// Concurrent checks on the ports of the frame statistics counter block.
`timescale 1ns/10ps
`include "msc_cfg.svh"
module msc_stats_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access
    input wire logic reg_sel,
    input wire logic [`MSC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`MSC_DATA_W-1:0] reg_wdata,
    input wire logic [`MSC_DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    // Statistics control and event
    input wire logic stats_global_enable,
    input wire logic stats_event_clear,
    input wire logic stats_threshold_event
);
    // One clock domain, so every check shares one clock and one reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // High when the offset names one of the four counters.
    logic rd_mapped;
    logic rd_short;
    assign rd_mapped = (reg_addr == `MSC_OFS_RX_GOOD) || (reg_addr == `MSC_OFS_TX_DEFER) ||
        rd_short;
    assign rd_short = (reg_addr == `MSC_OFS_RX_OVERRUN) || (reg_addr == `MSC_OFS_TX_EXCESS);

    // Read handshake: one registered valid per taken read, data held between reads.
    a_rvalid_after_read: assert property (reg_sel && reg_rd |=> reg_rvalid)
        else $error("read strobe not answered by valid");
    a_rvalid_needs_read: assert property (reg_rvalid |-> $past(reg_sel && reg_rd))
        else $error("valid without a read one cycle earlier");
    a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (reg_sel && reg_rd && !rd_mapped |=> reg_rdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_upper_zero: assert property (
        reg_sel && reg_rd && rd_short |=> reg_rdata[31:16] == 16'h0)
        else $error("short counter read shows upper bits");

    // A load with counting stopped, then an idle cycle, then a read of the same
    // offset returns the low 16 bits written; the enable is low for the three cycles up to the load.
    a_write_readback: assert property (
        (!stats_global_enable)[*3] ##0 (reg_sel && reg_wr) ##1 !(reg_sel && reg_wr)
        ##1 (reg_sel && reg_rd && rd_mapped && reg_addr == $past(reg_addr, 2))
        |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3))
        else $error("counter load not seen on readback");

    // The event is sticky until cleared; with counting stopped a clear always wins.
    a_event_sticky: assert property (
        stats_threshold_event && !stats_event_clear |=> stats_threshold_event)
        else $error("threshold event dropped without clear");
    a_event_clear: assert property (
        (!stats_global_enable)[*4] ##0 stats_event_clear |=> !stats_threshold_event)
        else $error("threshold event survived clear");
endmodule : msc_stats_sva

bind msc_stats msc_stats_sva u_msc_stats_sva (.clk(clk), .rstn(rstn), .reg_sel(reg_sel),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .stats_global_enable(stats_global_enable),
    .stats_event_clear(stats_event_clear), .stats_threshold_event(stats_threshold_event));

// *** msc_stats_tb_top.sv ***
// Self-checking bench for the frame statistics counter block.
`timescale 1ns/10ps
`include "msc_cfg.svh"
module msc_stats_tb_top;
    // Stimulus, all driven from time zero.
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic rx_start = 1'b0, rx_fifo_full = 1'b0, rx_overrun = 1'b0, rx_end = 1'b0;
    logic rx_addr_match = 1'b0;
    logic [3:0] rx_err = 4'h0;
    logic tx_start = 1'b0, tx_defer = 1'b0, tx_collision = 1'b0, tx_excess_defer = 1'b0;
    logic tx_end = 1'b0, stats_event_clear = 1'b0, stats_global_enable = 1'b0;
    logic [3:0] stats_counter_mask = 4'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid, stats_threshold_event;
    // Reference model state and score.
    logic [31:0] exp_cnt [4];
    logic ev_exp;
    int miscompares = 0;
    int check_count = 0;
    logic [7:0] ofs [4] = '{`MSC_OFS_RX_OVERRUN, `MSC_OFS_TX_EXCESS, `MSC_OFS_RX_GOOD,
        `MSC_OFS_TX_DEFER};

    msc_stats u_msc_stats (.clk(clk), .rstn(rstn), .reg_sel(reg_sel), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .stats_global_enable(stats_global_enable),
        .stats_counter_mask(stats_counter_mask), .rx_start(rx_start),
        .rx_fifo_full(rx_fifo_full), .rx_overrun(rx_overrun), .rx_end(rx_end),
        .rx_addr_match(rx_addr_match), .rx_too_long(rx_err[3]), .rx_fcs_err(rx_err[2]),
        .rx_len_err(rx_err[1]), .rx_align_err(rx_err[0]), .tx_start(tx_start),
        .tx_defer(tx_defer), .tx_collision(tx_collision), .tx_excess_defer(tx_excess_defer),
        .tx_end(tx_end), .stats_event_clear(stats_event_clear),
        .stats_threshold_event(stats_threshold_event));

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    // Counter limits and thresholds, indexed like the mask bits.
    function automatic logic [31:0] lim(input int i);
        return (i < 2) ? 32'h0000ffff : 32'hffffffff;
    endfunction : lim
    function automatic logic [31:0] thr(input int i);
        return (i < 2) ? {16'h0000, `MSC_THRESH16} : `MSC_THRESH32;
    endfunction : thr

    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        check_count++;
        if (seen !== expd) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Model step: only an enabled, unmasked counter moves; it may raise the event.
    task automatic bump(input int i);
        if (stats_global_enable && !stats_counter_mask[i]) begin
            exp_cnt[i] = (exp_cnt[i] + 32'h1) & lim(i);
            if (exp_cnt[i] == thr(i)) ev_exp = 1'b1;
        end
    endtask : bump
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_sel <= 1'b0;
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_sel <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, e);
    endtask : rd_chk
    // One receive frame; the model counts it once the pipeline has settled.
    task automatic rx_frame(input logic full, input logic ovr, input logic match,
        input logic [3:0] err);
        @(posedge clk);
        rx_start <= 1'b1;
        rx_fifo_full <= full;
        @(posedge clk);
        rx_start <= 1'b0;
        rx_overrun <= ovr;
        @(posedge clk);
        rx_overrun <= 1'b0;
        rx_end <= 1'b1;
        rx_addr_match <= match;
        rx_err <= err;
        @(posedge clk);
        rx_end <= 1'b0;
        rx_fifo_full <= 1'b0;
        cyc(3);
        if (!full && match && ovr) bump(0);
        if (!full && match && !ovr && err == 4'h0) bump(2);
    endtask : rx_frame
    // One transmit frame with nex separate excess-deferral pulses.
    task automatic tx_frame(input logic dfr, input logic col, input int nex);
        @(posedge clk);
        tx_start <= 1'b1;
        tx_defer <= dfr;
        @(posedge clk);
        tx_start <= 1'b0;
        tx_defer <= 1'b0;
        tx_collision <= col;
        repeat (nex) begin
            @(posedge clk);
            tx_collision <= 1'b0;
            tx_excess_defer <= 1'b1;
            @(posedge clk);
            tx_excess_defer <= 1'b0;
        end
        @(posedge clk);
        tx_collision <= 1'b0;
        tx_end <= 1'b1;
        @(posedge clk);
        tx_end <= 1'b0;
        cyc(3);
        if (dfr && !col) bump(3);
        if (nex > 0) bump(1);
    endtask : tx_frame
    // A frame that advances only counter i.
    task automatic hit(input int i);
        case (i)
            0: rx_frame(1'b0, 1'b1, 1'b1, 4'h0);
            1: tx_frame(1'b0, 1'b0, 2);
            2: rx_frame(1'b0, 1'b0, 1'b1, 4'h0);
            default: tx_frame(1'b1, 1'b0, 0);
        endcase
    endtask : hit
    task automatic chk_all();
        for (int i = 0; i < 4; i++) begin
            rd_chk(ofs[i], exp_cnt[i]);
        end
        chk({31'h0, stats_threshold_event}, {31'h0, ev_exp});
    endtask : chk_all
    // Stop counting long enough to flush pending increments, then clear.
    task automatic clr_event();
        @(posedge clk);
        stats_global_enable <= 1'b0;
        cyc(5);
        stats_event_clear <= 1'b1;
        @(posedge clk);
        stats_event_clear <= 1'b0;
        ev_exp = 1'b0;
        #1;
        chk({31'h0, stats_threshold_event}, 32'h0);
    endtask : clr_event
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Watchdog sized well above the fewer than two thousand cycles the tests take.
    initial begin
        #(40 * 20000);
        miscompares++;
        close_out();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h44fa));
        ev_exp = 1'b0;
        cyc(6);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            exp_cnt[i] = 32'h0;
            rd_chk(ofs[i], 32'h0);
        end
        wr(8'h00, 32'hffffffff);
        rd_chk(8'h00, 32'h0);
        for (int i = 0; i < 4; i++) begin
            exp_cnt[i] = $urandom & lim(i);
            wr(ofs[i], exp_cnt[i] | ~lim(i));
            rd_chk(ofs[i], exp_cnt[i]);
        end
        $display("test reset_and_load done");
        for (int n = 0; n < 60; n++) begin
            @(posedge clk);
            stats_global_enable <= ($urandom % 4) != 0;
            stats_counter_mask <= 4'($urandom);
            rx_frame(($urandom % 4) == 0, ($urandom % 3) == 0, ($urandom % 4) != 0,
                (($urandom % 3) == 0) ? 4'(1 << ($urandom % 4)) : 4'h0);
            tx_frame(1'($urandom), ($urandom % 4) == 0, $urandom % 3);
        end
        chk_all();
        $display("test random_traffic done");
        for (int i = 0; i < 4; i++) begin
            clr_event();
            wr(ofs[i], thr(i));
            cyc(2);
            #1;
            chk({31'h0, stats_threshold_event}, 32'h0);
            wr(ofs[i], lim(i));
            exp_cnt[i] = lim(i);
            @(posedge clk);
            stats_global_enable <= 1'b1;
            stats_counter_mask <= 4'h0;
            hit(i);
            rd_chk(ofs[i], 32'h0);
            wr(ofs[i], thr(i) - 32'h1);
            exp_cnt[i] = thr(i) - 32'h1;
            hit(i);
            chk_all();
            hit(i);
            chk_all();
        end
        $display("test wrap_and_threshold done");
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            stats_global_enable <= 1'(m);
            stats_counter_mask <= (m != 0) ? 4'hf : 4'h0;
            for (int i = 0; i < 4; i++) begin
                hit(i);
            end
            chk_all();
        end
        @(posedge clk);
        stats_counter_mask <= 4'h0;
        rx_frame(1'b1, 1'b1, 1'b1, 4'h0);
        for (int e = 0; e < 4; e++) begin
            rx_frame(1'b0, 1'b0, 1'b1, 4'(1 << e));
        end
        tx_frame(1'b1, 1'b1, 0);
        tx_frame(1'b0, 1'b0, 5);
        chk_all();
        $display("test gating_and_exclusions done");
        close_out();
    end
endmodule : msc_stats_tb_top
